// ---- dpms_regs.svh ----
`ifndef DPMS_REGS_SVH
`define DPMS_REGS_SVH

// =====================================================
// register addresses and special register numbers
`define DPMS_WDCFG_ADDR 24'h2fc004
`define DPMS_SPR_CAUSE 10'h094
`define DPMS_SPR_DXEN 10'h095
`define DPMS_SPR_ISC 10'h09e

// =====================================================
// reset values and field positions
`define DPMS_WDCFG_RESET 32'h0000ff84
`define DPMS_WDCFG_SWE_BIT 2
`define DPMS_WDCFG_BME_BIT 7
`define DPMS_DXEN_RESET 32'h00000000
`define DPMS_ISC_RESET 32'h00000000
`define DPMS_CAUSE_RESET 32'h00000000
`define DPMS_MSTATE_RESET 32'h00000000
`define DPMS_SAVED_RESET 32'h00000000
`define DPMS_PC_RESET 32'h00000000

// =====================================================
// debug message layout
`define DPMS_MSG_BITS 37
`define DPMS_MSG_OP_MSB 36
`define DPMS_MSG_OP_LSB 33
`define DPMS_MSG_DATA_MSB 31
`define DPMS_MSG_LAST 6'h24

// =====================================================
// timing counts
`define DPMS_SETTLE_CYCLES 2'h2

`endif

// ---- dpms_pkg.sv ----
package dpms_pkg;

    // =====================================================
    // shared pin function; 2'b11 never used
    typedef enum logic [1:0] {
        DPMS_PIN_DEBUG = 2'b00,
        DPMS_PIN_TRACE = 2'b01,
        DPMS_PIN_SCAN = 2'b10
    } dpms_pin_mode_e;

    // =====================================================
    // pin selection sequencing
    typedef enum logic [1:0] {
        DPMS_SEL_SETTLE = 2'b00,
        DPMS_SEL_WINDOW = 2'b01,
        DPMS_SEL_LOCKED = 2'b10
    } dpms_sel_state_e;

    // =====================================================
    // debug message operations
    typedef enum logic [3:0] {
        DPMS_OP_NOP = 4'h0,
        DPMS_OP_WR_DXEN = 4'h1,
        DPMS_OP_WR_ISC = 4'h2,
        DPMS_OP_WR_SAVED_PC = 4'h3,
        DPMS_OP_WR_SAVED_STATE = 4'h4,
        DPMS_OP_RD_MSTATE = 4'h5,
        DPMS_OP_RD_CAUSE = 4'h6,
        DPMS_OP_RETURN = 4'h7,
        DPMS_OP_WR_WDCFG = 4'h8,
        DPMS_OP_RD_DXEN = 4'h9
    } dpms_op_e;

    typedef struct packed {
        logic [5:0] cnt;
        logic [36:0] shift;
        logic [36:0] word;
        logic tgl;
    } dpms_rx_s;

endpackage

// ---- dpms_link_if.sv ----
`timescale 1ns/10ps

// word crosses as held data plus a toggle
interface dpms_link_if;
    logic [36:0] msg_word;
    logic msg_tgl;

    modport rx (
        output msg_word,
        output msg_tgl
    );

    modport core (
        input msg_word,
        input msg_tgl
    );
endinterface

// ---- dpms_serial_rx.sv ----
`timescale 1ns/10ps
`include "dpms_regs.svh"

module dpms_serial_rx (
    input wire logic dbg_clk_in,
    input wire logic rst_b_in,
    input wire logic frame_in,
    input wire logic debug_serial_in,
    dpms_link_if.rx link
);

    dpms_pkg::dpms_rx_s st_q;
    dpms_pkg::dpms_rx_s st_d;

    // =====================================================
    // shift, msb first; count restarts outside a frame
    always_comb begin
        st_d = st_q;
        if (!frame_in) begin
            st_d.cnt = 6'h00;
        end else begin
            st_d.shift = {st_q.shift[35:0], debug_serial_in};
            if (st_q.cnt == `DPMS_MSG_LAST) begin
                // word held stable until the next full message
                st_d.word = {st_q.shift[35:0], debug_serial_in};
                st_d.tgl = ~st_q.tgl;
                st_d.cnt = 6'h00;
            end else begin
                st_d.cnt = st_q.cnt + 6'h01;
            end
        end
    end

    always_ff @(posedge dbg_clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            st_q <= '0;
        end else begin
            st_q <= st_d;
        end
    end

    assign link.msg_word = st_q.word;
    assign link.msg_tgl = st_q.tgl;

endmodule // dpms_serial_rx

// ---- dpms_mode_init.sv ----
`timescale 1ns/10ps
`include "dpms_regs.svh"

//
// Summary of operation
// - compliance select low gives debug pins
// - compliance select high gives scan pins
// - sample compliance select at power-on release
// - select drop before hard release gives trace
// - watchdog runs after reset
// - watchdog config accepts first write only
// - bus monitor kept enabled in debug
// - debug registers writable from port in debug and in run mode
// - software writes to debug registers ignored in debug mode
// - exception cause read clears pending bits
// - return op restores state and runs
module dpms_mode_init (
    input wire logic clk_in,
    input wire logic rst_b_in,
    input wire logic dbg_clk_in,
    input wire logic debug_frame_in,
    input wire logic debug_serial_in,
    input wire logic scan_compliance_select_in,
    input wire logic hard_reset_n_in,
    input wire logic sw_wr_in,
    input wire logic [23:0] sw_addr_in,
    input wire logic sw_spr_wr_in,
    input wire logic [9:0] sw_spr_num_in,
    input wire logic [31:0] sw_wdata_in,
    input wire logic [31:0] exc_event_in,
    output logic [1:0] pin_mode_out,
    output logic mode_locked_out,
    output logic debug_mode_out,
    output logic core_run_out,
    output logic watchdog_enable_out,
    output logic bus_monitor_enable_out,
    output logic [31:0] watchdog_bus_monitor_config_out,
    output logic [31:0] debug_exception_enable_out,
    output logic [31:0] instruction_support_control_out,
    output logic [31:0] machine_state_register_out,
    output logic [31:0] core_pc_out,
    output logic core_pc_load_out,
    output logic [31:0] dbg_rdata_out,
    output logic dbg_rvalid_out
);

    typedef struct packed {
        logic cmp_s1;
        logic cmp_s2;
        logic hrst_s1;
        logic hrst_s2;
        logic tgl_s1;
        logic tgl_s2;
        logic tgl_s3;
        logic [1:0] settle;
        dpms_pkg::dpms_sel_state_e sel;
        dpms_pkg::dpms_pin_mode_e mode;
        logic locked;
        logic dbg;
        logic run;
        logic wdcfg_done;
        logic [31:0] wdcfg;
        logic [31:0] dxen;
        logic [31:0] isc;
        logic [31:0] cause;
        logic [31:0] saved_pc;
        logic [31:0] saved_state;
        logic [31:0] mstate;
        logic [31:0] pc;
        logic pc_load;
        logic [31:0] rdata;
        logic rvalid;
        logic wdt_en;
        logic bmon_en;
    } dpms_core_s;

    localparam dpms_core_s CORE_RESET = '{
        cmp_s1: 1'b0,
        cmp_s2: 1'b0,
        hrst_s1: 1'b0,
        hrst_s2: 1'b0,
        tgl_s1: 1'b0,
        tgl_s2: 1'b0,
        tgl_s3: 1'b0,
        settle: 2'h0,
        sel: dpms_pkg::DPMS_SEL_SETTLE,
        mode: dpms_pkg::DPMS_PIN_DEBUG,
        locked: 1'b0,
        dbg: 1'b1,
        run: 1'b0,
        wdcfg_done: 1'b0,
        wdcfg: `DPMS_WDCFG_RESET,
        dxen: `DPMS_DXEN_RESET,
        isc: `DPMS_ISC_RESET,
        cause: `DPMS_CAUSE_RESET,
        saved_pc: `DPMS_SAVED_RESET,
        saved_state: `DPMS_SAVED_RESET,
        mstate: `DPMS_MSTATE_RESET,
        pc: `DPMS_PC_RESET,
        pc_load: 1'b0,
        rdata: 32'h00000000,
        rvalid: 1'b0,
        wdt_en: 1'b1,
        bmon_en: 1'b1
    };

    dpms_core_s st_q;
    dpms_core_s st_d;
    dpms_link_if link ();

    // =====================================================
    // link clock domain: serial capture
    dpms_serial_rx u_rx (
        .dbg_clk_in(dbg_clk_in),
        .rst_b_in(rst_b_in),
        .frame_in(debug_frame_in),
        .debug_serial_in(debug_serial_in),
        .link(link)
    );

    // =====================================================
    // helpers
    function automatic logic [31:0] wr_once(
        input logic done,
        input logic [31:0] cur,
        input logic [31:0] val
    );
        // a second write after power-on leaves the value alone
        return done ? cur : val;
    endfunction

    logic msg_new;
    dpms_pkg::dpms_op_e msg_op;
    logic [31:0] msg_data;
    logic port_ok;
    logic sw_dev_ok;
    logic [31:0] cause_clr;

    // =====================================================
    // next state
    always_comb begin
        st_d = st_q;
        msg_new = 1'b0;
        msg_op = dpms_pkg::DPMS_OP_NOP;
        msg_data = 32'h00000000;
        port_ok = 1'b0;
        sw_dev_ok = 1'b0;
        cause_clr = 32'h00000000;

        // synchronisers for pins and the message toggle
        st_d.cmp_s1 = scan_compliance_select_in;
        st_d.cmp_s2 = st_q.cmp_s1;
        st_d.hrst_s1 = hard_reset_n_in;
        st_d.hrst_s2 = st_q.hrst_s1;
        st_d.tgl_s1 = link.msg_tgl;
        st_d.tgl_s2 = st_q.tgl_s1;
        st_d.tgl_s3 = st_q.tgl_s2;

        // =====================================================
        // pin function selection
        unique case (st_q.sel)
            dpms_pkg::DPMS_SEL_SETTLE: begin
                // wait for the synchroniser to carry a real sample
                if (st_q.settle == `DPMS_SETTLE_CYCLES) begin
                    st_d.sel = dpms_pkg::DPMS_SEL_WINDOW;
                    if (st_q.cmp_s2) begin
                        st_d.mode = dpms_pkg::DPMS_PIN_SCAN;
                    end else begin
                        st_d.mode = dpms_pkg::DPMS_PIN_DEBUG;
                    end
                end else begin
                    st_d.settle = st_q.settle + 2'h1;
                end
            end
            dpms_pkg::DPMS_SEL_WINDOW: begin
                if (st_q.hrst_s2) begin
                    st_d.sel = dpms_pkg::DPMS_SEL_LOCKED;
                end else if (st_q.mode == dpms_pkg::DPMS_PIN_SCAN && !st_q.cmp_s2) begin
                    st_d.mode = dpms_pkg::DPMS_PIN_TRACE;
                end
            end
            dpms_pkg::DPMS_SEL_LOCKED: begin
                st_d.sel = dpms_pkg::DPMS_SEL_LOCKED;
            end
            default: begin
                st_d.sel = dpms_pkg::DPMS_SEL_LOCKED;
            end
        endcase

        // =====================================================
        // debug message decode; ignored unless pins serve debug
        msg_new = st_q.tgl_s2 ^ st_q.tgl_s3;
        msg_op = dpms_pkg::dpms_op_e'(link.msg_word[`DPMS_MSG_OP_MSB:`DPMS_MSG_OP_LSB]);
        msg_data = link.msg_word[`DPMS_MSG_DATA_MSB:0];
        port_ok = msg_new && st_q.sel != dpms_pkg::DPMS_SEL_SETTLE
            && st_q.mode == dpms_pkg::DPMS_PIN_DEBUG;
        st_d.rvalid = 1'b0;
        st_d.pc_load = 1'b0;

        if (port_ok) begin
            unique case (msg_op)
                dpms_pkg::DPMS_OP_WR_DXEN: begin
                    st_d.dxen = msg_data;
                end
                dpms_pkg::DPMS_OP_WR_ISC: begin
                    st_d.isc = msg_data;
                end
                dpms_pkg::DPMS_OP_WR_SAVED_PC: begin
                    st_d.saved_pc = msg_data;
                end
                dpms_pkg::DPMS_OP_WR_SAVED_STATE: begin
                    st_d.saved_state = msg_data;
                end
                dpms_pkg::DPMS_OP_RD_MSTATE: begin
                    st_d.rdata = st_q.mstate;
                    st_d.rvalid = 1'b1;
                end
                dpms_pkg::DPMS_OP_RD_DXEN: begin
                    st_d.rdata = st_q.dxen;
                    st_d.rvalid = 1'b1;
                end
                dpms_pkg::DPMS_OP_RD_CAUSE: begin
                    st_d.rdata = st_q.cause;
                    st_d.rvalid = 1'b1;
                    cause_clr = st_q.cause;
                end
                dpms_pkg::DPMS_OP_RETURN: begin
                    if (st_q.dbg) begin
                        st_d.mstate = st_q.saved_state;
                        st_d.pc = st_q.saved_pc;
                        st_d.pc_load = 1'b1;
                        st_d.dbg = 1'b0;
                    end
                end
                dpms_pkg::DPMS_OP_WR_WDCFG: begin
                    st_d.wdcfg = wr_once(st_q.wdcfg_done, st_q.wdcfg, msg_data);
                    st_d.wdcfg_done = 1'b1;
                end
                default: begin
                    st_d.rvalid = 1'b0;
                end
            endcase
        end

        // =====================================================
        // software side writes
        if (sw_wr_in && sw_addr_in == `DPMS_WDCFG_ADDR) begin
            st_d.wdcfg = wr_once(st_q.wdcfg_done, st_q.wdcfg, sw_wdata_in);
            st_d.wdcfg_done = 1'b1;
        end
        // development registers frozen against software in debug
        sw_dev_ok = sw_spr_wr_in && !st_q.dbg;
        if (sw_dev_ok && sw_spr_num_in == `DPMS_SPR_DXEN) begin
            st_d.dxen = sw_wdata_in;
        end
        if (sw_dev_ok && sw_spr_num_in == `DPMS_SPR_ISC) begin
            st_d.isc = sw_wdata_in;
        end

        // =====================================================
        // exception cause: new events win over the read clear
        st_d.cause = (st_q.cause & ~cause_clr) | exc_event_in;
        if (!st_q.dbg && |(exc_event_in & st_q.dxen)) begin
            st_d.dbg = 1'b1;
        end

        // =====================================================
        // registered status outputs
        st_d.locked = (st_d.sel == dpms_pkg::DPMS_SEL_LOCKED);
        st_d.run = ~st_d.dbg;
        st_d.wdt_en = st_d.wdcfg[`DPMS_WDCFG_SWE_BIT];
        st_d.bmon_en = st_d.wdcfg[`DPMS_WDCFG_BME_BIT] | st_d.dbg;
    end

    always_ff @(posedge clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            st_q <= CORE_RESET;
        end else begin
            st_q <= st_d;
        end
    end

    // =====================================================
    // outputs straight from flops
    assign pin_mode_out = st_q.mode;
    assign mode_locked_out = st_q.locked;
    assign debug_mode_out = st_q.dbg;
    assign core_run_out = st_q.run;
    assign watchdog_enable_out = st_q.wdt_en;
    assign bus_monitor_enable_out = st_q.bmon_en;
    assign watchdog_bus_monitor_config_out = st_q.wdcfg;
    assign debug_exception_enable_out = st_q.dxen;
    assign instruction_support_control_out = st_q.isc;
    assign machine_state_register_out = st_q.mstate;
    assign core_pc_out = st_q.pc;
    assign core_pc_load_out = st_q.pc_load;
    assign dbg_rdata_out = st_q.rdata;
    assign dbg_rvalid_out = st_q.rvalid;

endmodule // dpms_mode_init

// ---- dpms_mode_init_chk.sv ----
`timescale 1ns/10ps
module dpms_mode_init_chk (
    input wire logic clk_in,
    input wire logic rst_b_in,
    input wire logic debug_frame_in,
    input wire logic scan_compliance_select_in,
    input wire logic hard_reset_n_in,
    input wire logic sw_spr_wr_in,
    input wire logic [9:0] sw_spr_num_in,
    input wire logic [1:0] pin_mode_out,
    input wire logic mode_locked_out,
    input wire logic debug_mode_out,
    input wire logic watchdog_enable_out,
    input wire logic bus_monitor_enable_out,
    input wire logic [31:0] watchdog_bus_monitor_config_out,
    input wire logic [31:0] debug_exception_enable_out,
    input wire logic [31:0] instruction_support_control_out,
    input wire logic core_pc_load_out,
    input wire logic dbg_rvalid_out
);
    logic [3:0] rel_q;
    logic [3:0] quiet_q;
    logic cfg_seen_q;

    default clocking cb @(posedge clk_in); endclocking
    default disable iff (!rst_b_in);

    // ====================
    // helpers
    // quiet_q keeps port writes landing late out of the software checks
    always_ff @(posedge clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            rel_q <= 4'h0;
            quiet_q <= 4'h0;
            cfg_seen_q <= 1'b0;
        end else begin
            rel_q <= (rel_q == 4'hf) ? rel_q : rel_q + 4'h1;
            quiet_q <= debug_frame_in ? 4'h0 : ((quiet_q == 4'hf) ? quiet_q : quiet_q + 4'h1);
            cfg_seen_q <= cfg_seen_q | $changed(watchdog_bus_monitor_config_out);
        end
    end

    // ====================
    // assertions
    sel_sample_a: assert property (rel_q == 4'h5 |->
        pin_mode_out == (scan_compliance_select_in ? 2'b10 : 2'b00)) else $error("pin mode not from select");
    mode_frozen_a: assert property (mode_locked_out |=> $stable(pin_mode_out))
        else $error("pin mode moved after lock");
    lock_after_hrst_a: assert property (hard_reset_n_in [*5] ##0 (rel_q > 4'h9) |-> mode_locked_out)
        else $error("selection not locked");
    trace_entry_a: assert property ($changed(pin_mode_out) && pin_mode_out == 2'b01 |->
        $past(pin_mode_out) == 2'b10 && !$past(scan_compliance_select_in, 2) && !$past(hard_reset_n_in, 3))
        else $error("trace entered wrongly");
    wdog_reset_a: assert property (rel_q == 4'h1 |-> watchdog_enable_out && debug_mode_out)
        else $error("watchdog or debug off after reset");
    bus_mon_a: assert property (debug_mode_out |-> bus_monitor_enable_out)
        else $error("bus monitor off in debug");
    cfg_once_a: assert property (cfg_seen_q |-> $stable(watchdog_bus_monitor_config_out))
        else $error("config written twice");
    enable_sw_block_a: assert property (debug_mode_out && sw_spr_wr_in && sw_spr_num_in == 10'h095 &&
        quiet_q == 4'hf |=> $stable(debug_exception_enable_out)) else $error("software changed enable reg");
    isc_sw_block_a: assert property (debug_mode_out && sw_spr_wr_in && sw_spr_num_in == 10'h09e &&
        quiet_q == 4'hf |=> $stable(instruction_support_control_out)) else $error("software changed support ctrl");
    run_exit_a: assert property ($fell(debug_mode_out) |-> core_pc_load_out || $past(core_pc_load_out))
        else $error("debug left without return");

    cover property (dbg_rvalid_out);
    cover property (core_pc_load_out);
    cover property (pin_mode_out == 2'b01);
endmodule // dpms_mode_init_chk

bind dpms_mode_init dpms_mode_init_chk dpms_mode_init_chk_i (.clk_in, .rst_b_in, .debug_frame_in,
    .scan_compliance_select_in, .hard_reset_n_in, .sw_spr_wr_in, .sw_spr_num_in, .pin_mode_out,
    .mode_locked_out, .debug_mode_out, .watchdog_enable_out, .bus_monitor_enable_out,
    .watchdog_bus_monitor_config_out, .debug_exception_enable_out, .instruction_support_control_out,
    .core_pc_load_out, .dbg_rvalid_out);

// ---- dpms_dbg_model.sv ----
`timescale 1ns/10ps
// debugger side; clock stands low between frames
module dpms_dbg_model (
    output logic dbg_clk_out,
    output logic frame_out,
    output logic serial_out
);
    initial begin
        dbg_clk_out = 1'b0;
        frame_out = 1'b0;
        serial_out = 1'b0;
    end

    task automatic send(input logic [3:0] op, input logic [31:0] data);
        logic [36:0] w;
        w = {op, 1'b0, data};
        frame_out = 1'b1;
        for (int i = 36; i >= 0; i--) begin
            serial_out = w[i];
            #3 dbg_clk_out = 1'b1;
            #3 dbg_clk_out = 1'b0;
        end
        frame_out = 1'b0;
        // released line must not keep the last bit
        serial_out = ~serial_out;
    endtask
endmodule // dpms_dbg_model

// ---- test_dpms_mode_init.sv ----
`timescale 1ns/10ps
module test_dpms_mode_init;
    logic clk_in = 1'b0;
    logic rst_b_in = 1'b0;
    logic scan_compliance_select_in = 1'b0;
    logic hard_reset_n_in = 1'b0;
    logic sw_wr_in = 1'b0;
    logic sw_spr_wr_in = 1'b0;
    logic [23:0] sw_addr_in = 24'h0;
    logic [9:0] sw_spr_num_in = 10'h0;
    logic [31:0] sw_wdata_in = 32'h0;
    logic [31:0] exc_event_in = 32'h0;
    logic dbg_clk_in, debug_frame_in, debug_serial_in, rv, pl;
    logic [1:0] pin_mode_out;
    logic mode_locked_out, debug_mode_out, core_run_out, watchdog_enable_out, bus_monitor_enable_out;
    logic core_pc_load_out, dbg_rvalid_out;
    logic [31:0] watchdog_bus_monitor_config_out, debug_exception_enable_out, instruction_support_control_out;
    logic [31:0] machine_state_register_out, core_pc_out, dbg_rdata_out, rd, r, pc;
    int miscompares = 0;
    int cmp_count = 0;

    always #2 clk_in = ~clk_in;

    dpms_mode_init dpms_mode_init_i (
        .clk_in, .rst_b_in, .dbg_clk_in, .debug_frame_in, .debug_serial_in, .scan_compliance_select_in,
        .hard_reset_n_in, .sw_wr_in, .sw_addr_in, .sw_spr_wr_in, .sw_spr_num_in, .sw_wdata_in, .exc_event_in,
        .pin_mode_out, .mode_locked_out, .debug_mode_out, .core_run_out, .watchdog_enable_out,
        .bus_monitor_enable_out, .watchdog_bus_monitor_config_out, .debug_exception_enable_out,
        .instruction_support_control_out, .machine_state_register_out, .core_pc_out, .core_pc_load_out,
        .dbg_rdata_out, .dbg_rvalid_out
    );
    dpms_dbg_model dpms_dbg_model_i (
        .dbg_clk_out(dbg_clk_in),
        .frame_out(debug_frame_in),
        .serial_out(debug_serial_in)
    );

    // ====================
    // tasks
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        cmp_count++;
        if (got !== exp) begin
            miscompares++;
            $display("wrong value %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic results;
        $display("comparisons %0d miscompares %0d", cmp_count, miscompares);
        if (miscompares == 0 && cmp_count > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    function automatic logic [1:0] exp_mode(input logic sel, input logic trace);
        return trace ? 2'b01 : (sel ? 2'b10 : 2'b00);
    endfunction

    // select stays put until well after sampling; hard reset held low across release
    task automatic do_reset(input logic sel, input logic trace);
        @(negedge clk_in);
        rst_b_in = 1'b0;
        hard_reset_n_in = 1'b0;
        scan_compliance_select_in = sel;
        repeat (6) @(negedge clk_in);
        rst_b_in = 1'b1;
        repeat (8) @(negedge clk_in);
        if (trace) begin
            scan_compliance_select_in = 1'b0;
            repeat (5) @(negedge clk_in);
        end
        hard_reset_n_in = 1'b1;
        repeat (6) @(negedge clk_in);
        chk("pin mode", {30'h0, exp_mode(sel, trace)}, {30'h0, pin_mode_out});
        chk("locked", 32'h1, {31'h0, mode_locked_out});
    endtask

    task automatic msg(input logic [3:0] op, input logic [31:0] data);
        dpms_dbg_model_i.send(op, data);
        rv = 1'b0;
        pl = 1'b0;
        repeat (16) begin
            @(negedge clk_in);
            if (dbg_rvalid_out === 1'b1) begin
                rv = 1'b1;
                rd = dbg_rdata_out;
            end
            if (core_pc_load_out === 1'b1) pl = 1'b1;
        end
    endtask

    task automatic sw(input logic spr, input logic [23:0] a, input logic [9:0] n, input logic [31:0] d);
        @(negedge clk_in);
        sw_wr_in = !spr;
        sw_spr_wr_in = spr;
        sw_addr_in = a;
        sw_spr_num_in = n;
        sw_wdata_in = d;
        @(negedge clk_in);
        sw_wr_in = 1'b0;
        sw_spr_wr_in = 1'b0;
        @(negedge clk_in);
    endtask

    // ====================
    // tests
    initial begin
        void'($urandom(32'h0df31530));
        do_reset(1'b0, 1'b0);
        chk("watchdog", 32'h1, {31'h0, watchdog_enable_out});
        chk("bus monitor", 32'h1, {31'h0, bus_monitor_enable_out});
        scan_compliance_select_in = 1'b1;
        repeat (6) @(negedge clk_in);
        chk("held mode", 32'h0, {30'h0, pin_mode_out});
        r = $urandom;
        sw(1'b1, 24'h0, 10'h095, r);
        sw(1'b1, 24'h0, 10'h09e, r);
        chk("enable sw", 32'h0, debug_exception_enable_out);
        chk("isc sw", 32'h0, instruction_support_control_out);
        msg(4'h1, 32'h7fe7540f);
        chk("enable port", 32'h7fe7540f, debug_exception_enable_out);
        msg(4'h9, 32'h0);
        chk("enable read", 32'h7fe7540f, rd);
        msg(4'h2, r);
        chk("isc port", r, instruction_support_control_out);
        sw(1'b0, 24'h2fc284, 10'h0, 32'h00400000);
        chk("config other addr", 32'h0000ff84, watchdog_bus_monitor_config_out);
        msg(4'h8, 32'h0000ff00);
        chk("watchdog off", 32'h0, {31'h0, watchdog_enable_out});
        msg(4'h8, 32'h0000ff80);
        sw(1'b0, 24'h2fc004, 10'h0, 32'h0000ff84);
        chk("config", 32'h0000ff00, watchdog_bus_monitor_config_out);
        @(negedge clk_in);
        exc_event_in = r;
        @(negedge clk_in);
        exc_event_in = 32'h0;
        msg(4'h6, 32'h0);
        chk("cause", r, rd);
        msg(4'h6, 32'h0);
        chk("cause clear", 32'h0, rd);
        msg(4'h5, 32'h0);
        chk("state read", 32'h1, {31'h0, rv});
        pc = $urandom;
        msg(4'h3, pc);
        msg(4'h4, 32'h00003002);
        msg(4'h7, 32'h0);
        chk("pc load", 32'h1, {31'h0, pl});
        chk("pc", pc, core_pc_out);
        chk("state", 32'h00003002, machine_state_register_out);
        chk("run", 32'h1, {31'h0, core_run_out});
        msg(4'h2, ~r);
        chk("isc run", ~r, instruction_support_control_out);
        exc_event_in = 32'h1;
        @(negedge clk_in);
        exc_event_in = 32'h0;
        repeat (3) @(negedge clk_in);
        chk("reentry", 32'h1, {31'h0, debug_mode_out});
        do_reset(1'b1, 1'b0);
        chk("config reset", 32'h0000ff84, watchdog_bus_monitor_config_out);
        scan_compliance_select_in = 1'b0;
        repeat (6) @(negedge clk_in);
        chk("scan held", 32'h2, {30'h0, pin_mode_out});
        do_reset(1'b1, 1'b1);
        results;
    end

    // whole run is about 4 us
    initial begin
        #200000;
        miscompares++;
        results;
    end
endmodule // test_dpms_mode_init
